// *** hw/cwd_pkg.sv ***
package cwd_pkg;
  // -------------------------------------------------------
  // register map
  // -------------------------------------------------------
  localparam logic [3:0] CFG_WORD_OFS = 4'h0;
  localparam logic [3:0] CTRL_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] DECODE_OFS = 4'hc;
  localparam logic [15:0] CFG_WORD_INDEX = 16'h2007;
  localparam logic [13:0] CFG_RESET = 14'h3fff;
  localparam logic [13:0] CFG_UNIMPL_MASK = 14'h0600;
  localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
  // -------------------------------------------------------
  // field positions
  // -------------------------------------------------------
  localparam int CODE_PROT_BIT = 13;
  localparam int CAPTURE_PIN_BIT = 12;
  localparam int DEBUG_BIT = 11;
  localparam int BOR_VOLT_HI = 8;
  localparam int BOR_VOLT_LO = 7;
  localparam int BOR_SEL_BIT = 6;
  localparam int RESET_PIN_BIT = 5;
  localparam int OSC_HI_BIT = 4;
  localparam int PWRUP_BIT = 3;
  localparam int WDT_BIT = 2;
  localparam int OSC_MID_BIT = 1;
  localparam int OSC_LO_BIT = 0;
  localparam int CTRL_SW_BOR_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam logic [1:0] BOR_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_RUN_ONLY = 2'h2;
  localparam logic [1:0] BOR_SOFTWARE = 2'h1;
  // -------------------------------------------------------
  // oscillator modes
  // -------------------------------------------------------
  typedef enum logic [2:0] {
    CWD_OSC_LP = 3'h0,
    CWD_OSC_XT = 3'h1,
    CWD_OSC_HS = 3'h2,
    CWD_OSC_EXTCK = 3'h3,
    CWD_OSC_INTERNAL_RC_OSCILLATOR = 3'h4,
    CWD_OSC_RSVD = 3'h5,
    CWD_OSC_EXTERNAL_RC_OSCILLATOR_IO = 3'h6,
    CWD_OSC_EXTERNAL_RC_OSCILLATOR_CK = 3'h7
  } cwd_osc_e;
endpackage

// *** hw/cwd_osc_if.sv ***
`timescale 1ns/1ns
interface cwd_osc_if;
  logic [2:0] oscillator_select;
  logic external_rc_oscillator;
  logic internal_rc_oscillator;
  logic external_clock_input;
  logic high_speed_crystal;
  logic standard_crystal;
  logic low_power_crystal;
  logic clock_out_signal;
  logic first_pin_gpio;
  logic second_pin_gpio;
  modport src (input oscillator_select);
  modport dec (
    input oscillator_select,
    output external_rc_oscillator, internal_rc_oscillator, external_clock_input,
    output high_speed_crystal, standard_crystal, low_power_crystal,
    output clock_out_signal, first_pin_gpio, second_pin_gpio
  );
  modport use_side (
    input external_rc_oscillator, internal_rc_oscillator, external_clock_input,
    input high_speed_crystal, standard_crystal, low_power_crystal,
    input clock_out_signal, first_pin_gpio, second_pin_gpio
  );
endinterface // cwd_osc_if

// *** hw/cwd_osc_decode.sv ***
`timescale 1ns/1ns
module cwd_osc_decode
  import cwd_pkg::*;
(
  // oscillator mode in, decoded out
  cwd_osc_if.dec osc
);
  cwd_osc_e mode;
  assign mode = cwd_osc_e'(osc.oscillator_select);
  assign osc.external_rc_oscillator = (mode == CWD_OSC_EXTERNAL_RC_OSCILLATOR_CK) || (mode == CWD_OSC_EXTERNAL_RC_OSCILLATOR_IO);
  assign osc.clock_out_signal = (mode == CWD_OSC_EXTERNAL_RC_OSCILLATOR_CK);
  assign osc.internal_rc_oscillator = (mode == CWD_OSC_INTERNAL_RC_OSCILLATOR);
  assign osc.external_clock_input = (mode == CWD_OSC_EXTCK);
  assign osc.high_speed_crystal = (mode == CWD_OSC_HS);
  assign osc.standard_crystal = (mode == CWD_OSC_XT);
  assign osc.low_power_crystal = (mode == CWD_OSC_LP);
  assign osc.first_pin_gpio = (mode == CWD_OSC_INTERNAL_RC_OSCILLATOR);
  assign osc.second_pin_gpio = (mode == CWD_OSC_EXTERNAL_RC_OSCILLATOR_IO) || (mode == CWD_OSC_INTERNAL_RC_OSCILLATOR)
                               || (mode == CWD_OSC_EXTCK);
endmodule // cwd_osc_decode

// *** hw/cwd_config_word_decode.sv ***
// How it works
// - bit 12 moves unit two pin
// - bit 11 low gives debugger port B pins
// - bits 10 and 9 read back one
// - code 01: software bit drives brown-out
// - code 10: brown-out off during sleep
// - reset pin function or input, reset high
// - bit 3 low enables power-up timer
// - mode field at bits 4, 1, 0
// - mode 111 external RC, clock out
// - mode 110 external RC, second pin I/O
// - mode 100 internal RC, both pins I/O
// - mode 011 external clock, second pin I/O
// - modes 010/001/000 crystal kinds
`timescale 1ns/1ns
module cwd_config_word_decode
  import cwd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // stored configuration word
  input wire logic [13:0] stored_config_word,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // core status pins
  input wire logic sleep_active,
  input wire logic reset_program_pin,
  // pin multiplexing
  output logic capture_compare_unit_two_on_portc_bit_one,
  output logic capture_compare_unit_two_on_portb_bit_three,
  output logic debugger_owns_portb_bit_six_seven,
  // reset and supervision
  output logic brownout_reset_active,
  output logic external_reset_input,
  output logic reset_pin_is_digital_input,
  output logic powerup_delay_enable,
  output logic watchdog_enable,
  output logic code_protect_n,
  output logic [1:0] brownout_voltage_select,
  // oscillator
  output logic [2:0] oscillator_select,
  output logic external_rc_oscillator,
  output logic internal_rc_oscillator,
  output logic external_clock_input,
  output logic high_speed_crystal,
  output logic standard_crystal,
  output logic low_power_crystal,
  output logic clock_out_signal,
  output logic first_pin_gpio,
  output logic second_pin_gpio
);
  import cwd_pkg::*;

  // --------------------------------------------------------
  // state
  // --------------------------------------------------------
  typedef struct packed {
    logic loaded;
    logic [13:0] word;
    logic software_brownout_enable;
    logic brownout_sleep_select;
    logic sleep_s1;
    logic sleep_s2;
    logic pin_s1;
    logic pin_s2;
    logic ack;
    logic [31:0] rdata;
  } cwd_state_s;

  cwd_state_s st;
  cwd_state_s next_st;

  function automatic logic cwd_hit(input logic [3:0] a, input logic [3:0] ofs);
    cwd_hit = (a == ofs);
  endfunction

  // --------------------------------------------------------
  // decoded fields
  // --------------------------------------------------------
  logic [1:0] bor_code;
  logic bor_on;
  logic [13:0] read_word;
  assign read_word = st.word | CFG_UNIMPL_MASK;
  // second code bit is the control register's sleep select, set after reset
  assign bor_code = {st.word[BOR_SEL_BIT], st.brownout_sleep_select};
  always_comb
  begin
    bor_on = 1'b0;
    case (bor_code)
      BOR_ALWAYS: bor_on = 1'b1;
      BOR_RUN_ONLY: bor_on = !st.sleep_s2;
      BOR_SOFTWARE: bor_on = st.software_brownout_enable;
      default: bor_on = 1'b0;
    endcase
  end

  // --------------------------------------------------------
  // next state
  // --------------------------------------------------------
  logic req;
  assign req = avs_read || avs_write;
  always_comb
  begin
    next_st = st;
    next_st.sleep_s1 = sleep_active;
    next_st.sleep_s2 = st.sleep_s1;
    next_st.pin_s1 = reset_program_pin;
    next_st.pin_s2 = st.pin_s1;
    if (!st.loaded)
    begin
      next_st.word = stored_config_word;
      next_st.loaded = 1'b1;
    end
    next_st.ack = req && !st.ack;
    if (avs_read && !st.ack)
    begin
      next_st.rdata = UNMAPPED_VALUE;
      if (cwd_hit(avs_address, CFG_WORD_OFS))
        next_st.rdata = {18'h0_0000, read_word};
      else if (cwd_hit(avs_address, CTRL_OFS))
        next_st.rdata = {30'h0000_0000, st.brownout_sleep_select,
                         st.software_brownout_enable};
      else if (cwd_hit(avs_address, STATUS_OFS))
        next_st.rdata = {29'h0000_0000, st.sleep_s2, bor_on, st.loaded};
      else if (cwd_hit(avs_address, DECODE_OFS))
        next_st.rdata = {29'h0000_0000, oscillator_select};
    end
    // write lands on the edge where waitrequest is seen low
    if (avs_write && st.ack && cwd_hit(avs_address, CTRL_OFS) && avs_byteenable[0])
    begin
      next_st.software_brownout_enable = avs_writedata[CTRL_SW_BOR_BIT];
      next_st.brownout_sleep_select = avs_writedata[CTRL_SLEEP_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      st <= '{loaded: 1'b0, word: CFG_RESET, software_brownout_enable: 1'b0,
              brownout_sleep_select: 1'b1,
              sleep_s1: 1'b0, sleep_s2: 1'b0, pin_s1: 1'b1, pin_s2: 1'b1,
              ack: 1'b0, rdata: 32'h0000_0000};
    else
      st <= next_st;
  end

  // --------------------------------------------------------
  // outputs
  // --------------------------------------------------------
  assign avs_waitrequest = req && !st.ack;
  assign avs_readdata = st.rdata;
  assign capture_compare_unit_two_on_portc_bit_one = st.word[CAPTURE_PIN_BIT];
  assign capture_compare_unit_two_on_portb_bit_three = !st.word[CAPTURE_PIN_BIT];
  assign debugger_owns_portb_bit_six_seven = !st.word[DEBUG_BIT];
  assign brownout_reset_active = bor_on;
  assign reset_pin_is_digital_input = !st.word[RESET_PIN_BIT];
  // gated high when pin is plain input
  assign external_reset_input = st.word[RESET_PIN_BIT] ? st.pin_s2 : 1'b1;
  assign powerup_delay_enable = !st.word[PWRUP_BIT];
  assign watchdog_enable = st.word[WDT_BIT];
  assign code_protect_n = st.word[CODE_PROT_BIT];
  assign brownout_voltage_select = {st.word[BOR_VOLT_HI], st.word[BOR_VOLT_LO]};
  // split mode field
  assign oscillator_select = {st.word[OSC_HI_BIT], st.word[OSC_MID_BIT],
                              st.word[OSC_LO_BIT]};

  cwd_osc_if osc_bus ();
  assign osc_bus.oscillator_select = oscillator_select;
  cwd_osc_decode u_osc (.osc(osc_bus));
  assign external_rc_oscillator = osc_bus.external_rc_oscillator;
  assign internal_rc_oscillator = osc_bus.internal_rc_oscillator;
  assign external_clock_input = osc_bus.external_clock_input;
  assign high_speed_crystal = osc_bus.high_speed_crystal;
  assign standard_crystal = osc_bus.standard_crystal;
  assign low_power_crystal = osc_bus.low_power_crystal;
  assign clock_out_signal = osc_bus.clock_out_signal;
  assign first_pin_gpio = osc_bus.first_pin_gpio;
  assign second_pin_gpio = osc_bus.second_pin_gpio;

  // --------------------------------------------------------
  // checks
  // --------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ccp_pin_a: assert property (capture_compare_unit_two_on_portc_bit_one
    != capture_compare_unit_two_on_portb_bit_three) else $error("unit two pin");
  debug_pins_a: assert property (debugger_owns_portb_bit_six_seven == !st.word[DEBUG_BIT])
    else $error("debugger pin owner");
  unimpl_read_a: assert property (avs_read && !avs_waitrequest && st.ack
    && $past(avs_address) == CFG_WORD_OFS |-> avs_readdata[10:9] == 2'b11)
    else $error("unimplemented bits");
  sw_bor_a: assert property (bor_code == BOR_SOFTWARE |->
    brownout_reset_active == st.software_brownout_enable)
    else $error("software brownout");
  sleep_bor_a: assert property (bor_code == BOR_RUN_ONLY && $past(sleep_active, 2)
    && $past(sleep_active, 1) && sleep_active && st.loaded |-> !brownout_reset_active)
    else $error("sleep brownout");
  reset_gate_a: assert property (!st.word[RESET_PIN_BIT] |-> external_reset_input)
    else $error("reset pin gate");
  powerup_a: assert property (powerup_delay_enable != st.word[PWRUP_BIT])
    else $error("powerup polarity");
  osc_field_a: assert property (oscillator_select[2] == st.word[OSC_HI_BIT])
    else $error("osc field");
  clkout_a: assert property (clock_out_signal |-> external_rc_oscillator
    && !second_pin_gpio) else $error("clock out");
  word_hold_a: assert property (st.loaded |=> $stable(st.word))
    else $error("word changed");
  wait_one_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");

  read_cov_c: cover property (avs_read && !avs_waitrequest);
  write_cov_c: cover property (avs_write && !avs_waitrequest);
  internal_rc_oscillator_cov_c: cover property (internal_rc_oscillator);
  sleep_cov_c: cover property (bor_code == BOR_RUN_ONLY && !brownout_reset_active);
endmodule // cwd_config_word_decode

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import cwd_pkg::*;
  // -------------------------------------------------------
  // stimulus and observed signals
  // -------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] stored_config_word = CFG_RESET;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sleep_active = 1'b0;
  logic reset_program_pin = 1'b0;
  logic [7:0] ctl;
  logic [2:0] osc;
  logic [8:0] fl;
  logic [1:0] bor_v;
  logic cp_n;
  logic [19:0] got_v;
  logic [31:0] q;
  int n_errors = 0;
  int num_checks = 0;

  assign got_v = {ctl, osc, fl};

  always #50 core_clk = ~core_clk;

  cwd_config_word_decode dut (
    .core_clk(core_clk), .rst(rst), .stored_config_word(stored_config_word),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sleep_active(sleep_active), .reset_program_pin(reset_program_pin),
    .capture_compare_unit_two_on_portc_bit_one(ctl[7]),
    .capture_compare_unit_two_on_portb_bit_three(ctl[6]),
    .debugger_owns_portb_bit_six_seven(ctl[5]), .brownout_reset_active(ctl[4]),
    .external_reset_input(ctl[3]), .reset_pin_is_digital_input(ctl[2]),
    .powerup_delay_enable(ctl[1]), .watchdog_enable(ctl[0]), .code_protect_n(cp_n),
    .brownout_voltage_select(bor_v), .oscillator_select(osc),
    .external_rc_oscillator(fl[8]), .internal_rc_oscillator(fl[7]),
    .external_clock_input(fl[6]), .high_speed_crystal(fl[5]), .standard_crystal(fl[4]),
    .low_power_crystal(fl[3]), .clock_out_signal(fl[2]), .first_pin_gpio(fl[1]),
    .second_pin_gpio(fl[0])
  );

  // -------------------------------------------------------
  // expected decode of one word
  // -------------------------------------------------------
  function automatic logic [19:0] expect_out(input logic [13:0] w, input logic pin);
    logic [2:0] m;
    m = {w[4], w[1], w[0]};
    return {w[12], !w[12], !w[11], w[6], w[5] ? pin : 1'b1, !w[5], !w[3], w[2], m,
      m[2:1] == 2'h3, m == 3'h4, m == 3'h3, m == 3'h2, m == 3'h1, m == 3'h0,
      m == 3'h7, m == 3'h4, m == 3'h6 || m == 3'h4 || m == 3'h3};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // -------------------------------------------------------
  // avalon access, held until waitrequest low
  // -------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50)
      check(32'h0000_0001, 32'h0000_0000, "bus answer");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic restart(input logic [13:0] w);
    @(posedge core_clk);
    rst <= 1'b1;
    stored_config_word <= w;
    repeat (2) @(posedge core_clk);
    check({12'h000, got_v & 20'hf_7fff}, {12'h000, expect_out(CFG_RESET, 1'b0) & 20'hf_7fff},
      "defaults in reset");
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  // -------------------------------------------------------
  // tests
  // -------------------------------------------------------
  initial
  begin
    logic [13:0] w;
    for (int i = 0; i < 8; i++)
    begin
      w = i[0] ? 14'h2b5a : 14'h14a5;
      w[4] = i[2];
      w[1] = i[1];
      w[0] = i[0];
      reset_program_pin <= i[1];
      sleep_active <= i[2];
      restart(w);
      check({12'h000, got_v}, {12'h000, expect_out(w, i[1])}, "decode");
      bus(1'b0, CFG_WORD_OFS, 32'h0000_0000, q);
      check(q, {18'h0_0000, w | CFG_UNIMPL_MASK}, "word read");
      bus(1'b0, DECODE_OFS, 32'h0000_0000, q);
      check(q, {29'h0000_0000, w[4], w[1], w[0]}, "mode read");
      reset_program_pin <= !i[1];
      stored_config_word <= ~w;
      repeat (4) @(posedge core_clk);
      check({12'h000, got_v}, {12'h000, expect_out(w, !i[1])}, "held");
    end
    bus(1'b1, CTRL_OFS, 32'h0000_0001, q);
    bus(1'b0, CTRL_OFS, 32'h0000_0000, q);
    check({31'h0000_0000, q[0]}, 32'h0000_0001, "ctrl bit");
    check({31'h0000_0000, ctl[4]}, 32'h0000_0000, "bor off in sleep");
    sleep_active <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({31'h0000_0000, ctl[4]}, 32'h0000_0001, "bor on awake");
    restart(14'h14a5);
    bus(1'b1, CTRL_OFS, 32'h0000_0003, q);
    @(posedge core_clk);
    check({31'h0000_0000, ctl[4]}, 32'h0000_0001, "software bor on");
    bus(1'b1, CTRL_OFS, 32'h0000_0002, q);
    @(posedge core_clk);
    check({31'h0000_0000, ctl[4]}, 32'h0000_0000, "software bor off");
    w = 14'h14a5;
    bus(1'b1, CFG_WORD_OFS, 32'h0000_0000, q);
    bus(1'b0, CFG_WORD_OFS, 32'h0000_0000, q);
    check(q, {18'h0_0000, w | CFG_UNIMPL_MASK}, "word read only");
    bus(1'b1, 4'h2, 32'hffff_ffff, q);
    bus(1'b0, 4'h2, 32'h0000_0000, q);
    check(q, UNMAPPED_VALUE, "unmapped");
    close_out;
  end

  initial
  begin
    #(100 * 3000);
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    close_out;
  end
endmodule // tb_top
